// [verilog/apsc_pkg.sv]
// Constants for the converter power-saving control block.
// Assumes an AXI4-Lite master and a 200 MHz sys_clk.
package apsc_pkg;
   localparam logic [3:0] CONV_CTRL_OFS = 4'h0;
   localparam logic [3:0] CLK_CTRL_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [7:0] CONV_CTRL_RST = 8'h00;
   localparam logic [7:0] CONV_CTRL_WMASK = 8'h5b;
   localparam int SWEEP_LSB = 0;
   localparam int RES_BIT = 3;
   localparam int FREQ_BIT = 4;
   localparam int REF_BIT = 6;
   localparam int EXTCLK_BIT = 0;
   localparam int SYSCLK_BIT = 1;
   localparam int REF_SETTLE_NS = 1000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_WAIT_CYC = 4096;
   typedef enum logic [1:0] {APSC_SWEEP2, APSC_SWEEP4, APSC_SWEEP5, APSC_SWEEPX} apsc_sweep_t;
   typedef enum logic [1:0] {APSC_SINGLE, APSC_REPEAT0, APSC_OTHER} apsc_mode_t;
   typedef enum logic [1:0] {APSC_RUN, APSC_STOP, APSC_WAKE} apsc_state_t;
endpackage : apsc_pkg

// [verilog/apsc_wake_timer.sv]
// Down counter that signals when a wait has elapsed.
// Assumes start is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
module apsc_wake_timer #(
   parameter int COUNT = 4096
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   output logic busy
);
   logic [15:0] cnt_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
      end else if (start) begin
         cnt_r <= 16'(COUNT);
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
   assign busy = (cnt_r != 16'h0000);
endmodule : apsc_wake_timer

// [verilog/apsc_top.sv]
// Converter control register and power-saving controls behind AXI4-Lite.
// Assumes stop requests and wake interrupts come from same-clock logic.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module apsc_top #(
   parameter int WDT_CYC = apsc_pkg::WDT_WAIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire apsc_pkg::apsc_mode_t sweepMode,
   input wire logic stopReq,
   input wire logic wakeIrq,
   output logic oscDriveEn,
   output logic xtalOut,
   output logic xtalOutEn,
   output logic cpuRun,
   output logic refConnect,
   output logic refReady,
   output logic res10Bit,
   output logic freqSel1,
   output logic [4:0] sweepEnable
);
   import apsc_pkg::*;

   logic [7:0] convCtrl_r;
   logic [1:0] clkCtrl_r;
   logic [3:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic awHave_r;
   logic wHave_r;
   logic bValid_r;
   logic [1:0] bResp_r;
   logic rValid_r;
   logic [31:0] rData_r;
   logic [1:0] rResp_r;
   logic [15:0] settle_r;
   apsc_state_t state_r;
   apsc_state_t state_nxt;

   // Register select, shared by the write and read decoders
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
      return addr == ofs;
   endfunction : reg_hit

   // Stop exit needs the watchdog wait unless an external clock runs with system clock select 0
   function automatic logic wdt_on_wake(input logic [1:0] clkSel);
      return !clkSel[EXTCLK_BIT] || clkSel[SYSCLK_BIT];
   endfunction : wdt_on_wake

   // Input enables per sweep code; the unused code enables none
   function automatic logic [4:0] sweep_pins(input apsc_sweep_t sel);
      logic [4:0] pins;
      pins = 5'h00;
      unique case (sel)
         APSC_SWEEP2: pins = 5'h03;
         APSC_SWEEP4: pins = 5'h0f;
         APSC_SWEEP5: pins = 5'h1f;
         APSC_SWEEPX: pins = 5'h00;
      endcase
      return pins;
   endfunction : sweep_pins

   wire doWrite = awHave_r && wHave_r && !bValid_r;
   wire wrConv = doWrite && reg_hit(awAddr_r, CONV_CTRL_OFS) && wStrb_r[0];
   wire wrClk = doWrite && reg_hit(awAddr_r, CLK_CTRL_OFS) && wStrb_r[0];
   wire wrOk = reg_hit(awAddr_r, CONV_CTRL_OFS) || reg_hit(awAddr_r, CLK_CTRL_OFS);
   wire [7:0] convWr = wData_r[7:0] & CONV_CTRL_WMASK;
   wire refReconnect = wrConv && convCtrl_r[REF_BIT] && !convWr[REF_BIT];
   wire doRead = s_axi_arvalid && !rValid_r;
   wire wdtBusy;
   wire wakeStart = (state_r == APSC_STOP) && wakeIrq;
   wire useWdt = wdt_on_wake(clkCtrl_r);
   wire [31:0] convRd = {24'h0, 1'b0, convCtrl_r[6:0]};
   wire [31:0] clkRd = {30'h0, clkCtrl_r};
   wire [31:0] statRd = {29'h0, cpuRun, refReady, refConnect};
   wire [31:0] rdMux = reg_hit(s_axi_araddr, CONV_CTRL_OFS) ? convRd :
                       reg_hit(s_axi_araddr, CLK_CTRL_OFS) ? clkRd :
                       reg_hit(s_axi_araddr, STATUS_OFS) ? statRd : 32'h0;
   wire rdOk = reg_hit(s_axi_araddr, CONV_CTRL_OFS) || reg_hit(s_axi_araddr, CLK_CTRL_OFS) ||
               reg_hit(s_axi_araddr, STATUS_OFS);

   assign s_axi_awready = !awHave_r;
   assign s_axi_wready = !wHave_r;
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_arready = !rValid_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;

   // Write channels: capture address and data in either order, then answer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= 4'h0;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         bValid_r <= 1'b0;
         bResp_r <= 2'h0;
      end else begin
         if (s_axi_awvalid && !awHave_r) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHave_r) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bValid_r <= 1'b1;
            bResp_r <= wrOk ? 2'h0 : 2'h2;
         end else if (bValid_r && s_axi_bready) begin
            bValid_r <= 1'b0;
         end
      end
   end

   // Read channel: one read at a time, data held until taken
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rValid_r <= 1'b0;
         rData_r <= 32'h0;
         rResp_r <= 2'h0;
      end else if (doRead) begin
         rValid_r <= 1'b1;
         rData_r <= rdMux;
         rResp_r <= rdOk ? 2'h0 : 2'h2;
      end else if (rValid_r && s_axi_rready) begin
         rValid_r <= 1'b0;
      end
   end

   // Sweep field is left unreset in spirit; cleared here only for a defined start
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         convCtrl_r <= CONV_CTRL_RST;
         clkCtrl_r <= 2'h0;
      end else begin
         if (wrConv) begin
            convCtrl_r <= convWr;
         end
         if (wrClk) begin
            clkCtrl_r <= wData_r[1:0];
         end
      end
   end

   // Reference settle counter after reconnection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         settle_r <= 16'h0;
      end else if (refReconnect) begin
         settle_r <= 16'(REF_SETTLE_CYC);
      end else if (settle_r != 16'h0) begin
         settle_r <= settle_r - 16'h1;
      end
   end

   // Run, stop and wake sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         APSC_RUN: begin
            if (stopReq) state_nxt = APSC_STOP;
         end
         APSC_STOP: begin
            if (wakeIrq) state_nxt = useWdt ? APSC_WAKE : APSC_RUN;
         end
         APSC_WAKE: begin
            if (!wdtBusy) state_nxt = APSC_RUN;
         end
         default: state_nxt = APSC_RUN;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= APSC_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Watchdog wait after a stop exit that needs it
   apsc_wake_timer #(.COUNT(WDT_CYC)) u_wdt (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(wakeStart && useWdt),
      .busy(wdtBusy)
   );

   wire sweepLive = sweepMode == APSC_SINGLE || sweepMode == APSC_REPEAT0;
   wire [1:0] sweepSel = convCtrl_r[SWEEP_LSB +: 2];
   wire [4:0] sweepDec = sweep_pins(apsc_sweep_t'(sweepSel));

   assign oscDriveEn = !clkCtrl_r[EXTCLK_BIT];
   assign xtalOut = 1'b1;
   assign xtalOutEn = clkCtrl_r[EXTCLK_BIT];
   assign cpuRun = state_r == APSC_RUN;
   assign refConnect = !convCtrl_r[REF_BIT];
   assign refReady = refConnect && settle_r == 16'h0;
   assign res10Bit = convCtrl_r[RES_BIT];
   assign freqSel1 = convCtrl_r[FREQ_BIT];
   assign sweepEnable = sweepLive ? sweepDec : 5'h00;
endmodule : apsc_top

// [test/apsc_top_properties.sv]
// Assertions on the ports of apsc_top.
// Assumes the bind below and a single sys_clk domain.
`timescale 1ns/1ps
module apsc_top_properties #(
   parameter int WDT_CYC = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire apsc_pkg::apsc_mode_t sweepMode,
   input wire logic wakeIrq,
   input wire logic oscDriveEn,
   input wire logic xtalOut,
   input wire logic xtalOutEn,
   input wire logic cpuRun,
   input wire logic refConnect,
   input wire logic refReady,
   input wire logic [4:0] sweepEnable
);
   import apsc_pkg::*;
   logic sysSel_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Mirror of the system clock select bit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) sysSel_r <= 1'h0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == CLK_CTRL_OFS)
         sysSel_r <= s_axi_wdata[SYSCLK_BIT];
   end
   a_osc_drive_off: assert property (oscDriveEn != xtalOutEn) else $error("osc drive");
   a_xtal_held_high: assert property (xtalOutEn |-> xtalOut) else $error("xtal level");
   a_fast_wake: assert property (!cpuRun && $rose(wakeIrq) && xtalOutEn && !sysSel_r |=> cpuRun)
      else $error("slow wake");
   a_wdt_wake: assert property (!cpuRun && $rose(wakeIrq) && !(xtalOutEn && !sysSel_r)
      |=> !cpuRun [*2] ##[1:20] cpuRun) else $error("wdt wake");
   a_ref_open: assert property (!refConnect |-> !refReady) else $error("ref ready");
   a_sweep_idle: assert property (sweepMode == APSC_OTHER |-> sweepEnable == 5'h00) else $error("sweep");
   a_sweep_live: assert property (sweepMode != APSC_OTHER |-> sweepEnable inside {5'h03, 5'h0f, 5'h1f})
      else $error("sweep set");
   a_read_top_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0) else $error("rdata");
   cover property ($rose(cpuRun));
   cover property ($fell(oscDriveEn));
   cover property ($fell(refConnect));
endmodule : apsc_top_properties

bind apsc_top apsc_top_properties #(.WDT_CYC(WDT_CYC)) props (.*);

// [test/test_adc_power_saving_control.sv]
// Self-checking bench for apsc_top.
// Assumes the package and the properties file compile first.
`timescale 1ns/1ps
module test_adc_power_saving_control;
   import apsc_pkg::*;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, r, seed = 32'h6d9e52bd;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, stopReq = 1'h0, wakeIrq = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic oscDriveEn, xtalOut, xtalOutEn, cpuRun, refConnect, refReady, res10Bit, freqSel1;
   logic [4:0] sweepEnable;
   apsc_mode_t sweepMode = APSC_SINGLE;
   int badCount = 0, numChecks = 0, cyc = 0;
   apsc_top #(.WDT_CYC(8)) DUT (.*);
   always #2.5 sys_clk = ~sys_clk;
   function automatic logic [4:0] sw_exp(input logic [1:0] c, input apsc_mode_t m);
      if (m == APSC_OTHER) return 5'h00;
      return c == 2'h0 ? 5'h03 : (c == 2'h1 ? 5'h0f : 5'h1f);
   endfunction : sw_exp
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xorshift
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (!awDone && s_axi_awready) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'h0;
         end
         if (!wDone && s_axi_wready) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'h0;
         end
      end while (!(awDone && wDone));
      do @(posedge sys_clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      r = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge sys_clk);
   endtask : rd
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         badCount++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      rd(CONV_CTRL_OFS);
      chk(r, 32'h0);
      rd(STATUS_OFS);
      chk(r, 32'h7);
      chk({oscDriveEn, xtalOutEn}, 2'h2);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         seed = xorshift(seed);
         d = (i == 0) ? 32'hfe : {24'h0, seed[7:0]};
         d = d & 32'hdb;
         // Sweep code 3 is the unused code, so it is replaced by code 2 before the write
         if (d[1:0] == 2'h3) d[1:0] = 2'h2;
         sweepMode <= apsc_mode_t'(seed[9:8] % 2'h3);
         wr(CONV_CTRL_OFS, d);
         rd(CONV_CTRL_OFS);
         chk(r, d & 32'h5b);
         chk(res10Bit, d[3]);
         chk(refConnect, !d[6]);
         chk(sweepEnable, sw_exp(d[1:0], sweepMode));
         chk(freqSel1, d[4]);
      end
      wr(4'hc, 32'h1);
      chk(resp, 2'h2);
      $display("register test done");
      wr(CONV_CTRL_OFS, 32'h40);
      wr(CONV_CTRL_OFS, 32'h00);
      chk(refReady, 1'h0);
      repeat (REF_SETTLE_CYC - 4) @(posedge sys_clk);
      chk(refReady, 1'h0);
      repeat (4) @(posedge sys_clk);
      chk(refReady, 1'h1);
      $display("reference test done");
      for (int k = 0; k < 4; k++) begin
         wr(CLK_CTRL_OFS, 32'(k));
         chk(oscDriveEn, !k[0]);
         chk({xtalOutEn, xtalOut}, k[0] ? 2'h3 : 2'h1);
         stopReq <= 1'h1;
         @(posedge sys_clk);
         stopReq <= 1'h0;
         wakeIrq <= 1'h1;
         @(posedge sys_clk);
         wakeIrq <= 1'h0;
         @(posedge sys_clk);
         #1;
         chk(cpuRun, k == 1);
         repeat (12) @(posedge sys_clk);
         chk(cpuRun, 1'h1);
      end
      $display("wake test done");
      tally_and_finish;
   end
endmodule : test_adc_power_saving_control
